// File: hdl/pcrc_pkg.sv
// constants, field layouts and carrier types of the peripheral clock/reset controller
// assumes a single 40 MHz system clock and a plain strobe register port
// Function
// - clock bits 13, 12 gate wakeup timer, basic timers
// - clock bits 9, 8, 7 gate serial, spi, advanced timer
// - clock bits 4, 2 gate comparator and converter
// - clock enable register resets to 0x8000
// - reset bit 0 holds module, 1 releases
// - fast bus reset: ports f,c,b,a at 9,6,5,4
// - fast bus reset: checksum 2, flash 1, dma 0
// - fast bus reset register resets to 0x277
// - periph reset 1: i2c 11, serial3 8, serial2 7
// - periph reset 1: watchdogs 5,4, rtc 3, timers 2,1
// - periph reset 1 resets to 0x9bf
// - periph reset 2: wakeup 13, basic 12, serial1 9
// - periph reset 2: spi 8, adv 7, comparator 4, adc 2
// - periph reset 2 resets to 0x339d
// - cause bit 9 soft request, bit 8 lockup
// - cause bit 5 window, bit 4 independent watchdog
// - writing 0 clears a flag, 1 leaves it
package pcrc_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] PCRC_OFS_CLKEN2 = 8'h34;
  localparam logic [7:0] PCRC_OFS_FASTRST = 8'h40;
  localparam logic [7:0] PCRC_OFS_RST2 = 8'h44;
  localparam logic [7:0] PCRC_OFS_RST1 = 8'h48;
  localparam logic [7:0] PCRC_OFS_FLAGS = 8'h4c;
  // reset values
  localparam logic [31:0] PCRC_RST_CLKEN2 = 32'h0000_8000;
  localparam logic [31:0] PCRC_RST_FASTRST = 32'h0000_0277;
  localparam logic [31:0] PCRC_RST_RST2 = 32'h0000_339d;
  localparam logic [31:0] PCRC_RST_RST1 = 32'h0000_09bf;
  // flags after power-on: only the power-on flag set
  localparam logic [31:0] PCRC_RST_FLAGS = 32'h0000_0001;
  // writable bits; the rest hold their reset value
  localparam logic [31:0] PCRC_WM_CLKEN2 = 32'h0000_339c;
  localparam logic [31:0] PCRC_WM_FASTRST = 32'h0000_0277;
  localparam logic [31:0] PCRC_WM_RST2 = 32'h0000_3394;
  localparam logic [31:0] PCRC_WM_RST1 = 32'h0000_09be;
  localparam logic [31:0] PCRC_WM_FLAGS = 32'h0000_0379;
  // bit positions, group 2 (clock enable and reset 2 share them)
  localparam int PCRC_B_WAKE = 13;
  localparam int PCRC_B_BASIC = 12;
  localparam int PCRC_B_SER1 = 9;
  localparam int PCRC_B_SPI = 8;
  localparam int PCRC_B_ADV = 7;
  localparam int PCRC_B_CMP = 4;
  localparam int PCRC_B_ADC = 2;
  // bit positions, fast bus reset
  localparam int PCRC_B_PF = 9;
  localparam int PCRC_B_PC = 6;
  localparam int PCRC_B_PB = 5;
  localparam int PCRC_B_PA = 4;
  localparam int PCRC_B_CRC = 2;
  localparam int PCRC_B_FLASH = 1;
  localparam int PCRC_B_DMA = 0;
  // bit positions, periph reset 1
  localparam int PCRC_B_I2C = 11;
  localparam int PCRC_B_SER3 = 8;
  localparam int PCRC_B_SER2 = 7;
  localparam int PCRC_B_IWDG = 5;
  localparam int PCRC_B_WWDG = 4;
  localparam int PCRC_B_RTC = 3;
  localparam int PCRC_B_GT2 = 2;
  localparam int PCRC_B_GT1 = 1;
  // bit positions, reset cause flags
  localparam int PCRC_F_SOFT = 9;
  localparam int PCRC_F_LOCKUP = 8;
  localparam int PCRC_F_PIN = 6;
  localparam int PCRC_F_WWDG = 5;
  localparam int PCRC_F_IWDG = 4;
  localparam int PCRC_F_LOWV = 3;
  localparam int PCRC_F_POR = 0;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pcrc_bus_t;
  // reset cause events from the chip reset generator
  typedef struct packed {
    logic cpu_soft_reset_request;
    logic lockup;
    logic external_reset_pin;
    logic window_watchdog;
    logic independent_watchdog;
    logic low_voltage_detector;
    logic brown_out_reset;
  } pcrc_cause_t;
  // group 2 modules: used for clock enables and reset lines
  typedef struct packed {
    logic auto_wakeup_timer;
    logic basic_timers;
    logic first_async_serial;
    logic spi;
    logic advanced_timer;
    logic voltage_comparator;
    logic adc;
  } pcrc_grp2_t;
  // fast bus modules
  typedef struct packed {
    logic io_port_f;
    logic io_port_c;
    logic io_port_b;
    logic io_port_a;
    logic checksum;
    logic flash;
    logic dma;
  } pcrc_fast_t;
  // group 1 modules
  typedef struct packed {
    logic i2c;
    logic third_async_serial;
    logic second_async_serial;
    logic independent_watchdog;
    logic window_watchdog;
    logic rtc;
    logic general_timer_two;
    logic general_timer_one;
  } pcrc_grp1_t;
endpackage : pcrc_pkg

// File: hdl/pcrc_ctrl.sv
// peripheral clock gating, per-module reset lines and reset cause flags
// assumes one system clock; cause events arrive from reset logic on mclk
`timescale 1ns/1ps
module pcrc_ctrl (
  input wire logic mclk, // system clock, 40 MHz
  input wire logic rstn, // system reset, async, low
  input wire logic por_rstn, // power-on reset, async, low
  input wire pcrc_pkg::pcrc_bus_t bus, // register port request
  output logic [31:0] rdata, // read data, cycle after read strobe
  input wire pcrc_pkg::pcrc_cause_t cause, // reset cause event pulses
  output pcrc_pkg::pcrc_grp2_t clk_gate, // group 2 clock enables, high on
  output pcrc_pkg::pcrc_fast_t rst_fast_n, // fast bus module resets, low holds
  output pcrc_pkg::pcrc_grp1_t rst_grp1_n, // group 1 module resets, low holds
  output pcrc_pkg::pcrc_grp2_t rst_grp2_n // group 2 module resets, low holds
);
  import pcrc_pkg::*;

  // merge a write into a register: only writable bits change
  function automatic logic [31:0] merge_wr(input logic [31:0] wd, input logic [31:0] wm,
                                           input logic [31:0] rv);
    merge_wr = (wd & wm) | (rv & ~wm);
  endfunction : merge_wr

  // address match of a write strobe
  function automatic logic hit_wr(input pcrc_bus_t b, input logic [7:0] ofs);
    hit_wr = b.wr && (b.addr == ofs);
  endfunction : hit_wr

  logic [31:0] clken2_r; // group 2 clock enable register
  logic [31:0] fastrst_r; // fast bus reset register
  logic [31:0] rst1_r; // group 1 reset register
  logic [31:0] rst2_r; // group 2 reset register
  logic [31:0] flags_r; // reset cause flags
  logic [31:0] flags_nxt; // next value of the flags
  logic [31:0] flag_set; // events this cycle, placed at flag bits
  logic [31:0] flag_clr; // bits software writes to zero this cycle
  logic [31:0] rdata_nxt; // read mux output

  // clock enable register, system reset domain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      clken2_r <= PCRC_RST_CLKEN2;
    end else if (hit_wr(bus, PCRC_OFS_CLKEN2)) begin
      // reserved bits keep defaults even if software scribbles on them
      clken2_r <= merge_wr(bus.wdata, PCRC_WM_CLKEN2, PCRC_RST_CLKEN2);
    end
  end

  // fast bus reset register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fastrst_r <= PCRC_RST_FASTRST;
    end else if (hit_wr(bus, PCRC_OFS_FASTRST)) begin
      fastrst_r <= merge_wr(bus.wdata, PCRC_WM_FASTRST, PCRC_RST_FASTRST);
    end
  end

  // group 1 reset register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst1_r <= PCRC_RST_RST1;
    end else if (hit_wr(bus, PCRC_OFS_RST1)) begin
      rst1_r <= merge_wr(bus.wdata, PCRC_WM_RST1, PCRC_RST_RST1);
    end
  end

  // group 2 reset register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst2_r <= PCRC_RST_RST2;
    end else if (hit_wr(bus, PCRC_OFS_RST2)) begin
      rst2_r <= merge_wr(bus.wdata, PCRC_WM_RST2, PCRC_RST_RST2);
    end
  end

  // clock gates straight from register flops
  always_comb begin
    clk_gate.auto_wakeup_timer = clken2_r[PCRC_B_WAKE];
    clk_gate.basic_timers = clken2_r[PCRC_B_BASIC];
    clk_gate.first_async_serial = clken2_r[PCRC_B_SER1];
    clk_gate.spi = clken2_r[PCRC_B_SPI];
    clk_gate.advanced_timer = clken2_r[PCRC_B_ADV];
    clk_gate.voltage_comparator = clken2_r[PCRC_B_CMP];
    clk_gate.adc = clken2_r[PCRC_B_ADC];
  end

  // module reset lines; a zero bit holds the module in reset
  always_comb begin
    rst_fast_n.io_port_f = fastrst_r[PCRC_B_PF];
    rst_fast_n.io_port_c = fastrst_r[PCRC_B_PC];
    rst_fast_n.io_port_b = fastrst_r[PCRC_B_PB];
    rst_fast_n.io_port_a = fastrst_r[PCRC_B_PA];
    rst_fast_n.checksum = fastrst_r[PCRC_B_CRC];
    rst_fast_n.flash = fastrst_r[PCRC_B_FLASH];
    rst_fast_n.dma = fastrst_r[PCRC_B_DMA];
    rst_grp1_n.i2c = rst1_r[PCRC_B_I2C];
    rst_grp1_n.third_async_serial = rst1_r[PCRC_B_SER3];
    rst_grp1_n.second_async_serial = rst1_r[PCRC_B_SER2];
    rst_grp1_n.independent_watchdog = rst1_r[PCRC_B_IWDG];
    rst_grp1_n.window_watchdog = rst1_r[PCRC_B_WWDG];
    rst_grp1_n.rtc = rst1_r[PCRC_B_RTC];
    rst_grp1_n.general_timer_two = rst1_r[PCRC_B_GT2];
    rst_grp1_n.general_timer_one = rst1_r[PCRC_B_GT1];
    rst_grp2_n.auto_wakeup_timer = rst2_r[PCRC_B_WAKE];
    rst_grp2_n.basic_timers = rst2_r[PCRC_B_BASIC];
    rst_grp2_n.first_async_serial = rst2_r[PCRC_B_SER1];
    rst_grp2_n.spi = rst2_r[PCRC_B_SPI];
    rst_grp2_n.advanced_timer = rst2_r[PCRC_B_ADV];
    rst_grp2_n.voltage_comparator = rst2_r[PCRC_B_CMP];
    rst_grp2_n.adc = rst2_r[PCRC_B_ADC];
  end

  // cause events placed at their flag positions
  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[PCRC_F_SOFT] = cause.cpu_soft_reset_request;
    flag_set[PCRC_F_LOCKUP] = cause.lockup;
    flag_set[PCRC_F_PIN] = cause.external_reset_pin;
    flag_set[PCRC_F_WWDG] = cause.window_watchdog;
    flag_set[PCRC_F_IWDG] = cause.independent_watchdog;
    flag_set[PCRC_F_LOWV] = cause.low_voltage_detector;
    flag_set[PCRC_F_POR] = cause.brown_out_reset;
  end

  always_comb begin
    flag_clr = 32'h0000_0000;
    if (hit_wr(bus, PCRC_OFS_FLAGS)) begin
      flag_clr = ~bus.wdata & PCRC_WM_FLAGS;
    end
    // an event in the clearing cycle wins over the clear
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
  end

  // cause flags sit on the power-on reset only
  // survive system reset
  always_ff @(posedge mclk or negedge por_rstn) begin
    if (!por_rstn) begin
      flags_r <= PCRC_RST_FLAGS;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    case (bus.addr)
      PCRC_OFS_CLKEN2: rdata_nxt = clken2_r;
      PCRC_OFS_FASTRST: rdata_nxt = fastrst_r;
      PCRC_OFS_RST2: rdata_nxt = rst2_r;
      PCRC_OFS_RST1: rdata_nxt = rst1_r;
      PCRC_OFS_FLAGS: rdata_nxt = flags_r;
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h0000_0000;
    end else if (bus.rd) begin
      rdata <= rdata_nxt;
    end else begin
      rdata <= 32'h0000_0000;
    end
  end

  // clock enable register comes out of reset at its default
  property p_clken2_default;
    @(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> (clken2_r == 32'h0000_8000) && !clk_gate.adc && !clk_gate.spi;
  endproperty
  a_clken2_default: assert property (p_clken2_default) else $error("clock enable default wrong");

  // a write of one to the wakeup bit and zero to the basic bit opens the wakeup clock and keeps the basic clock shut next cycle
  property p_timer_gate;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h34 && bus.wdata[13] && !bus.wdata[12])
        |=> clk_gate.auto_wakeup_timer && !clk_gate.basic_timers ##1
            (clk_gate.auto_wakeup_timer || $past(bus.wr && bus.addr == 8'h34));
  endproperty
  a_timer_gate: assert property (p_timer_gate) else $error("timer clock gate wrong");

  // serial, spi and advanced timer gates follow written bits
  property p_mid_gate;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h34) |=> (clk_gate.first_async_serial == $past(bus.wdata[9]))
        && (clk_gate.spi == $past(bus.wdata[8])) && (clk_gate.advanced_timer == $past(bus.wdata[7]));
  endproperty
  a_mid_gate: assert property (p_mid_gate) else $error("serial or timer gate wrong");

  // comparator and converter gates, and reserved bit 15 stays one
  property p_analog_gate;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h34) |=> (clk_gate.voltage_comparator == $past(bus.wdata[4]))
        && (clk_gate.adc == $past(bus.wdata[2])) && clken2_r[15];
  endproperty
  a_analog_gate: assert property (p_analog_gate) else $error("analog gate wrong");

  // writing zero to dma and port a holds them in reset until rewritten
  property p_fast_hold;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h40 && !bus.wdata[0] && !bus.wdata[4])
        |=> (!rst_fast_n.dma && !rst_fast_n.io_port_a) ##1
            ((!rst_fast_n.dma && !rst_fast_n.io_port_a) || $past(bus.wr && bus.addr == 8'h40));
  endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast bus reset not held");

  // all reset registers leave system reset with modules running
  property p_reset_defaults;
    @(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> (fastrst_r == 32'h0000_0277) && (rst1_r == 32'h0000_09bf)
        && (rst2_r == 32'h0000_339d) && rst_grp1_n.i2c && rst_grp2_n.adc;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset register default wrong");

  // group 1 reset lines follow the written bits
  property p_grp1_lines;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h48) |=> (rst_grp1_n.i2c == $past(bus.wdata[11]))
        && (rst_grp1_n.window_watchdog == $past(bus.wdata[4])) && rst1_r[0];
  endproperty
  a_grp1_lines: assert property (p_grp1_lines) else $error("group 1 reset line wrong");

  // group 2 reset lines follow the written bits
  property p_grp2_lines;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h44) |=> (rst_grp2_n.auto_wakeup_timer == $past(bus.wdata[13]))
        && (rst_grp2_n.spi == $past(bus.wdata[8])) && rst2_r[0] && rst2_r[3];
  endproperty
  a_grp2_lines: assert property (p_grp2_lines) else $error("group 2 reset line wrong");

  // a soft request or lockup event sets its flag next cycle even under a clear
  property p_cpu_flags;
    @(posedge mclk) disable iff (!por_rstn)
      (cause.cpu_soft_reset_request || cause.lockup)
        |=> (flags_r[9] == $past(cause.cpu_soft_reset_request) || flags_r[9])
            && (flags_r[8] || !$past(cause.lockup));
  endproperty
  a_cpu_flags: assert property (p_cpu_flags) else $error("cpu cause flag not set");

  // pin reset event sets bit 6
  property p_pin_flag;
    @(posedge mclk) disable iff (!por_rstn)
      cause.external_reset_pin |=> flags_r[6];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin cause flag not set");

  // writing zero to the watchdog flag clears it when no event meets it
  property p_zero_clears;
    @(posedge mclk) disable iff (!por_rstn || !rstn)
      (bus.wr && bus.addr == 8'h4c && !bus.wdata[4] && !cause.independent_watchdog)
        |=> !flags_r[4];
  endproperty
  a_zero_clears: assert property (p_zero_clears) else $error("write zero did not clear");

  // writing all ones changes no flag without an event
  property p_one_keeps;
    @(posedge mclk) disable iff (!por_rstn)
      (bus.wr && bus.addr == 8'h4c && ((bus.wdata & 32'h0000_0379) == 32'h0000_0379)
        && (cause == 7'h00))
        |=> $stable(flags_r);
  endproperty
  a_one_keeps: assert property (p_one_keeps) else $error("write one changed a flag");

  // flags hold through system reset while no event arrives
  property p_flags_survive;
    @(posedge mclk) disable iff (!por_rstn)
      (!rstn && !bus.wr && (cause == 7'h00)) |=> $stable(flags_r);
  endproperty
  a_flags_survive: assert property (p_flags_survive) else $error("flags lost in reset");

  // read data stands in the cycle after the strobe only
  property p_read_timing;
    @(posedge mclk) disable iff (!rstn)
      (bus.rd && bus.addr == 8'h44) |=> (rdata == $past(rst2_r)) ##1 ($past(bus.rd) || rdata == 0);
  endproperty
  a_read_timing: assert property (p_read_timing) else $error("read data timing wrong");

  // io port reset lines follow the written bits
  property p_port_lines;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h40) |=> (rst_fast_n.io_port_f == $past(bus.wdata[9]))
        && (rst_fast_n.io_port_c == $past(bus.wdata[6])) && (rst_fast_n.io_port_b == $past(bus.wdata[5]))
        && (rst_fast_n.io_port_a == $past(bus.wdata[4]));
  endproperty
  a_port_lines: assert property (p_port_lines) else $error("port reset line wrong");

  // a zero bit holds flash and checksum, a one releases them
  property p_flash_lines;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h40) |=> (rst_fast_n.flash == $past(bus.wdata[1]))
        && (rst_fast_n.checksum == $past(bus.wdata[2]));
  endproperty
  a_flash_lines: assert property (p_flash_lines) else $error("reset polarity wrong");

  // i2c and serial port reset lines follow the written bits
  property p_grp1_serial;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h48) |=> (rst_grp1_n.i2c == $past(bus.wdata[11]))
        && (rst_grp1_n.third_async_serial == $past(bus.wdata[8]))
        && (rst_grp1_n.second_async_serial == $past(bus.wdata[7]));
  endproperty
  a_grp1_serial: assert property (p_grp1_serial) else $error("serial reset line wrong");

  // group 1 leaves system reset with every module running
  property p_grp1_default;
    @(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> (rst1_r == 32'h0000_09bf) && (rst_grp1_n == 8'hff);
  endproperty
  a_grp1_default: assert property (p_grp1_default) else $error("group 1 default wrong");

  // advanced timer, comparator and converter reset lines
  property p_grp2_analog;
    @(posedge mclk) disable iff (!rstn)
      (bus.wr && bus.addr == 8'h44) |=> (rst_grp2_n.advanced_timer == $past(bus.wdata[7]))
        && (rst_grp2_n.voltage_comparator == $past(bus.wdata[4]))
        && (rst_grp2_n.adc == $past(bus.wdata[2]));
  endproperty
  a_grp2_analog: assert property (p_grp2_analog) else $error("group 2 analog line wrong");

  // group 2 leaves system reset with every module running
  property p_grp2_default;
    @(posedge mclk) disable iff (!rstn)
      $rose(rstn) |-> (rst2_r == 32'h0000_339d) && (rst_grp2_n == 7'h7f);
  endproperty
  a_grp2_default: assert property (p_grp2_default) else $error("group 2 default wrong");

  // watchdog events set their flags next cycle
  property p_wdog_flags;
    @(posedge mclk) disable iff (!por_rstn)
      (cause.window_watchdog || cause.independent_watchdog)
        |=> (flags_r[5] || !$past(cause.window_watchdog))
            && (flags_r[4] || !$past(cause.independent_watchdog));
  endproperty
  a_wdog_flags: assert property (p_wdog_flags) else $error("watchdog flag not set");

  // low voltage and brown-out events set their flags next cycle
  property p_supply_flags;
    @(posedge mclk) disable iff (!por_rstn)
      (cause.low_voltage_detector || cause.brown_out_reset)
        |=> (flags_r[3] || !$past(cause.low_voltage_detector))
            && (flags_r[0] || !$past(cause.brown_out_reset));
  endproperty
  a_supply_flags: assert property (p_supply_flags) else $error("supply flag not set");

endmodule : pcrc_ctrl

// File: tb/tb_periph_clock_reset_ctrl.sv
// self-checking bench of the peripheral clock and reset controller
// assumes pcrc_pkg and pcrc_ctrl are compiled first; the bench drives every port itself
`timescale 1ns/1ps
module tb_periph_clock_reset_ctrl;
  import pcrc_pkg::*;
  // one ordinary case: a write and the read-back it should give
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rexp;
  } pcrc_row_t;
  logic mclk; // system clock
  logic rstn; // system reset, low
  logic por_rstn; // power-on reset, low
  pcrc_bus_t bus; // register port request
  logic [31:0] rdata; // read data
  pcrc_cause_t cause; // reset cause pulses
  pcrc_grp2_t clk_gate; // group 2 clock enables
  pcrc_fast_t rst_fast_n; // fast bus resets
  pcrc_grp1_t rst_grp1_n; // group 1 resets
  pcrc_grp2_t rst_grp2_n; // group 2 resets
  int mismatches; // failed comparisons
  int total_checks; // comparisons made
  logic [31:0] m34, m40, m44, m48, mflg; // expected register contents
  logic [31:0] got; // last read value
  int fpos [0:6]; // flag bit for each cause field, lsb field first
  pcrc_row_t rows [0:16]; // ordinary write/read-back cases

  pcrc_ctrl i_dut (
    .mclk(mclk),
    .rstn(rstn),
    .por_rstn(por_rstn),
    .bus(bus),
    .rdata(rdata),
    .cause(cause),
    .clk_gate(clk_gate),
    .rst_fast_n(rst_fast_n),
    .rst_grp1_n(rst_grp1_n),
    .rst_grp2_n(rst_grp2_n)
  );

  // 40 MHz clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // group 2 fields from register bits 13,12,9,8,7,4,2
  function automatic pcrc_grp2_t g2(input logic [31:0] v);
    return {v[13], v[12], v[9], v[8], v[7], v[4], v[2]};
  endfunction : g2

  // fast bus fields from bits 9,6,5,4,2,1,0
  function automatic pcrc_fast_t gf(input logic [31:0] v);
    return {v[9], v[6], v[5], v[4], v[2], v[1], v[0]};
  endfunction : gf

  // group 1 fields from bits 11,8,7,5,4,3,2,1
  function automatic pcrc_grp1_t g1(input logic [31:0] v);
    return {v[11], v[8], v[7], v[5], v[4], v[3], v[2], v[1]};
  endfunction : g1

  // compare and count; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe, released at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask : wr

  // one-cycle read strobe; data is taken in the following cycle only
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    got = rdata;
    chk(what, exp, got);
  endtask : rchk

  // all clock gate and reset outputs against the expected register contents
  task automatic check_outs();
    chk("clk_gate", 32'(g2(m34)), 32'(clk_gate));
    chk("rst_fast_n", 32'(gf(m40)), 32'(rst_fast_n));
    chk("rst_grp1_n", 32'(g1(m48)), 32'(rst_grp1_n));
    chk("rst_grp2_n", 32'(g2(m44)), 32'(rst_grp2_n));
  endtask : check_outs

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #(25 * 5000);
    mismatches++;
    end_of_test();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    por_rstn = 1'b0;
    bus = '0;
    cause = '0;
    mismatches = 0;
    total_checks = 0;
    fpos = '{0, 3, 4, 5, 6, 8, 9};
    // software keeps reserved bits at their defaults, so every write reads back as written
    rows = '{{8'h34, 32'h0000a000, 32'h0000a000}, {8'h34, 32'h00009000, 32'h00009000},
             {8'h34, 32'h00008200, 32'h00008200}, {8'h34, 32'h00008100, 32'h00008100},
             {8'h34, 32'h00008080, 32'h00008080}, {8'h34, 32'h00008010, 32'h00008010},
             {8'h34, 32'h00008004, 32'h00008004}, {8'h34, 32'h0000a280, 32'h0000a280},
             {8'h34, 32'h00009114, 32'h00009114}, {8'h34, 32'h0000b394, 32'h0000b394},
             {8'h40, 32'h00000055, 32'h00000055}, {8'h40, 32'h00000222, 32'h00000222},
             {8'h40, 32'h00000000, 32'h00000000}, {8'h44, 32'h00002289, 32'h00002289},
             {8'h44, 32'h0000111d, 32'h0000111d}, {8'h48, 32'h000008ab, 32'h000008ab},
             {8'h48, 32'h00000115, 32'h00000115}};
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    por_rstn <= 1'b1;
    // values straight after power-up
    m34 = 32'h00008000;
    m40 = 32'h00000277;
    m44 = 32'h0000339d;
    m48 = 32'h000009bf;
    mflg = 32'h00000001;
    check_outs();
    rchk("clken2", 8'h34, m34);
    rchk("fastrst", 8'h40, m40);
    rchk("rst2", 8'h44, m44);
    rchk("rst1", 8'h48, m48);
    rchk("flags", 8'h4c, mflg);
    $display("test reset values done");
    // ordinary cases: write, read back, follow the outputs
    for (int i = 0; i < 17; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rchk("row readback", rows[i].addr, rows[i].rexp);
      case (rows[i].addr)
        8'h34: m34 = rows[i].rexp;
        8'h40: m40 = rows[i].rexp;
        8'h44: m44 = rows[i].rexp;
        default: m48 = rows[i].rexp;
      endcase
      check_outs();
    end
    $display("test table done");
    // read data stands one cycle only; unmapped place reads zero and ignores writes
    rchk("clken2 again", 8'h34, m34);
    @(posedge mclk);
    #1;
    chk("rdata idle", 32'h0, rdata);
    wr(8'h38, 32'hffffffff);
    rchk("unmapped", 8'h38, 32'h0);
    check_outs();
    $display("test unmapped done");
    // every cause sets its own flag and only that flag
    wr(8'h4c, 32'h0);
    mflg = 32'h0;
    rchk("flags cleared", 8'h4c, mflg);
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      cause <= 7'h1 << i;
      @(posedge mclk);
      cause <= '0;
      mflg = mflg | (32'h1 << fpos[i]);
      rchk("flag set", 8'h4c, mflg);
    end
    wr(8'h4c, 32'h00000379);
    rchk("flags write ones", 8'h4c, mflg);
    $display("test cause flags done");
    // system reset in mid-run: registers back to defaults at once, flags kept
    @(posedge mclk);
    rstn <= 1'b0;
    #1;
    m34 = 32'h00008000;
    m40 = 32'h00000277;
    m44 = 32'h0000339d;
    m48 = 32'h000009bf;
    check_outs();
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    rchk("flags kept", 8'h4c, mflg);
    rchk("clken2 reset", 8'h34, m34);
    $display("test system reset done");
    // clearing one flag leaves the others
    wr(8'h4c, 32'h00000279);
    mflg = mflg & ~32'h00000100;
    rchk("flags lockup cleared", 8'h4c, mflg);
    wr(8'h4c, 32'h00000100);
    mflg = 32'h0;
    rchk("flags one clear", 8'h4c, mflg);
    // an event in the cycle of a clearing write still sets its flag
    @(posedge mclk);
    bus.addr <= 8'h4c;
    bus.wdata <= 32'h0;
    bus.wr <= 1'b1;
    cause <= 7'h20;
    @(posedge mclk);
    bus.wr <= 1'b0;
    cause <= '0;
    rchk("flags set wins", 8'h4c, 32'h00000100);
    // power-on reset leaves only the power-on flag
    @(posedge mclk);
    por_rstn <= 1'b0;
    @(posedge mclk);
    por_rstn <= 1'b1;
    rchk("flags power on", 8'h4c, 32'h00000001);
    $display("test power on done");
    end_of_test();
  end
endmodule : tb_periph_clock_reset_ctrl
